// ===== brr_regs.sv
// register bank: backplane error-test receiver setup and counter, stream rates
// assumes host strobes synchronous to sys_clk, one cycle each, never both
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module brr_regs #(
    parameter int unsigned LOCAL_N = 16,
    parameter int unsigned BP_N = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input brr_pkg::brr_req_t host_req,
    output logic [15:0] host_rdata,
    input brr_pkg::brr_rx_bit_t rx_bit,
    output logic [4:0] rx_stream,
    output logic [8:0] rx_first_channel,
    output logic [9:0] rx_channel_count,
    output logic rx_in_window,
    output brr_pkg::brr_rate_t local_in_rate [LOCAL_N],
    output brr_pkg::brr_rate_t local_out_rate [LOCAL_N],
    output brr_pkg::brr_rate_t bp_in_rate [BP_N],
    output brr_pkg::brr_rate_t bp_out_rate [BP_N]
);
    import brr_pkg::*;

    // ends of the local blocks; the gaps behind them are unmapped and read zero
    localparam logic [8:0] LIN_END = OFS_LOCAL_IN + 9'(LOCAL_N);
    localparam logic [8:0] LOUT_END = OFS_LOCAL_OUT + 9'(LOCAL_N);

    logic [8:0] bp_test_rx_length;
    logic [4:0] bp_test_rx_stream;
    logic [8:0] bp_test_rx_channel;
    logic [15:0] bp_test_error_count;
    logic local_fast_mode;
    logic backplane_fast_mode;
    logic bp_counter_clear;
    logic [1:0] lin_field [LOCAL_N];
    logic [1:0] lout_field [LOCAL_N];
    logic [1:0] bin_field [BP_N];
    logic [1:0] bout_field [BP_N];
    logic [15:0] next_rdata;
    logic [9:0] chan_end;
    logic hit;

    ////////////////////////////////////////////////////////////////////////////
    // receiver setup registers; reserved bits are simply not stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_test_rx_length <= '0;
            bp_test_rx_stream <= '0;
            bp_test_rx_channel <= '0;
        end else if (host_req.wr) begin
            if (host_req.addr == OFS_RX_LENGTH) begin
                bp_test_rx_length <= host_req.wdata[LEN_MSB:0];
            end
            if (host_req.addr == OFS_RX_START) begin
                bp_test_rx_stream <= host_req.wdata[STREAM_MSB:STREAM_LSB];
                bp_test_rx_channel <= host_req.wdata[CHAN_MSB:0];
            end
        end
    end

    // control bits; the clear bit is a self-clearing one-cycle command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            local_fast_mode <= 1'b0;
            backplane_fast_mode <= 1'b0;
            bp_counter_clear <= 1'b0;
        end else begin
            bp_counter_clear <= 1'b0;
            if (host_req.wr && host_req.addr == OFS_TEST_CTRL) begin
                bp_counter_clear <= host_req.wdata[CTRL_CLEAR_BIT];
                local_fast_mode <= host_req.wdata[CTRL_LFAST_BIT];
                backplane_fast_mode <= host_req.wdata[CTRL_BFAST_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare window: start channel up to start plus length, on the chosen stream
    assign rx_stream = bp_test_rx_stream;
    assign rx_first_channel = bp_test_rx_channel;
    assign rx_channel_count = {1'b0, bp_test_rx_length} + 10'd1;
    assign chan_end = {1'b0, bp_test_rx_channel} + {1'b0, bp_test_rx_length};
    assign hit = rx_bit.valid && rx_bit.stream == bp_test_rx_stream
        && {1'b0, rx_bit.channel} >= {1'b0, bp_test_rx_channel}
        && {1'b0, rx_bit.channel} <= chan_end;
    assign rx_in_window = hit;

    // error counter: one per mismatching bit, stuck at all ones until cleared;
    // an error arriving with the clear is dropped, since clear restarts the count
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_test_error_count <= REG_RESET;
        end else if (bp_counter_clear) begin
            bp_test_error_count <= REG_RESET;
        end else if (hit && rx_bit.bit_rx != rx_bit.bit_exp
                     && bp_test_error_count != COUNT_MAX) begin
            bp_test_error_count <= bp_test_error_count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // local rate fields and their effective rates
    for (genvar i = 0; i < LOCAL_N; i++) begin : g_local
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                lin_field[i] <= 2'h0;
                lout_field[i] <= 2'h0;
            end else if (host_req.wr) begin
                if (host_req.addr == OFS_LOCAL_IN + 9'(i)) begin
                    lin_field[i] <= host_req.wdata[1:0];
                end
                if (host_req.addr == OFS_LOCAL_OUT + 9'(i)) begin
                    lout_field[i] <= host_req.wdata[1:0];
                end
            end
        end
        // fast mode overrides the fields; upper half of the streams goes idle
        always_comb begin
            if (local_fast_mode) begin
                local_in_rate[i] = (i < LOCAL_N / 2) ? RATE_32M : RATE_UNUSED;
                local_out_rate[i] = (i < LOCAL_N / 2) ? RATE_32M : RATE_UNUSED;
            end else begin
                local_in_rate[i] = brr_rate_t'({1'b0, lin_field[i]});
                local_out_rate[i] = brr_rate_t'({1'b0, lout_field[i]});
            end
        end
    end

    // backplane rate fields and their effective rates
    for (genvar i = 0; i < BP_N; i++) begin : g_bp
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                bin_field[i] <= 2'h0;
                bout_field[i] <= 2'h0;
            end else if (host_req.wr) begin
                if (host_req.addr == OFS_BP_IN + 9'(i)) begin
                    bin_field[i] <= host_req.wdata[1:0];
                end
                if (host_req.addr == OFS_BP_OUT + 9'(i)) begin
                    bout_field[i] <= host_req.wdata[1:0];
                end
            end
        end
        always_comb begin
            if (backplane_fast_mode) begin
                bp_in_rate[i] = (i < BP_N / 2) ? RATE_32M : RATE_UNUSED;
                bp_out_rate[i] = (i < BP_N / 2) ? RATE_32M : RATE_UNUSED;
            end else begin
                bp_in_rate[i] = brr_rate_t'({1'b0, bin_field[i]});
                bp_out_rate[i] = brr_rate_t'({1'b0, bout_field[i]});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero, reserved bits read zero
    always_comb begin
        next_rdata = 16'h0000;
        if (host_req.addr == OFS_RX_LENGTH) begin
            next_rdata = {7'h00, bp_test_rx_length};
        end else if (host_req.addr == OFS_RX_START) begin
            next_rdata = {2'h0, bp_test_rx_stream, bp_test_rx_channel};
        end else if (host_req.addr == OFS_ERR_COUNT) begin
            next_rdata = bp_test_error_count;
        end else if (host_req.addr == OFS_TEST_CTRL) begin
            next_rdata = {13'h0000, backplane_fast_mode, local_fast_mode, 1'b0};
        end else if (host_req.addr >= OFS_LOCAL_IN && host_req.addr < LIN_END) begin
            next_rdata = {14'h0000, lin_field[4'(host_req.addr - OFS_LOCAL_IN)]};
        end else if (host_req.addr >= OFS_LOCAL_OUT && host_req.addr < LOUT_END) begin
            next_rdata = {14'h0000, lout_field[4'(host_req.addr - OFS_LOCAL_OUT)]};
        end else if (host_req.addr >= OFS_BP_IN && host_req.addr < OFS_BP_OUT) begin
            next_rdata = {14'h0000, bin_field[5'(host_req.addr - OFS_BP_IN)]};
        end else if (host_req.addr >= OFS_BP_OUT && host_req.addr < OFS_BP_OUT + 9'(BP_N)) begin
            next_rdata = {14'h0000, bout_field[5'(host_req.addr - OFS_BP_OUT)]};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata <= 16'h0000;
        end else begin
            host_rdata <= host_req.rd ? next_rdata : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on the error counter; the clear is the only way out of saturation
    a_count_saturates: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bp_test_error_count == COUNT_MAX && !bp_counter_clear
        |=> bp_test_error_count == COUNT_MAX)
        else $error("count left saturation");
    a_count_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        bp_counter_clear |=> bp_test_error_count == 16'h0000)
        else $error("count not cleared");
    a_count_steps: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        hit && rx_bit.bit_rx != rx_bit.bit_exp && !bp_counter_clear
        && bp_test_error_count != COUNT_MAX
        |=> bp_test_error_count == $past(bp_test_error_count) + 16'h0001)
        else $error("mismatch not counted");
    // a matching bit, or any bit outside the window, leaves the count alone
    a_count_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !bp_counter_clear && !(hit && rx_bit.bit_rx != rx_bit.bit_exp)
        |=> $stable(bp_test_error_count))
        else $error("count moved without an error");
    a_count_ro: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        host_req.wr && host_req.addr == OFS_ERR_COUNT && !bp_counter_clear && !hit
        |=> $stable(bp_test_error_count))
        else $error("count changed by write");
    a_count_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        host_req.rd && host_req.addr == OFS_ERR_COUNT
        |=> host_rdata == $past(bp_test_error_count))
        else $error("count read back wrong");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the receiver setup and the compare window
    a_len_plus_one: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        host_req.wr && host_req.addr == OFS_RX_LENGTH
        |=> rx_channel_count == {1'b0, $past(host_req.wdata[8:0])} + 10'h001)
        else $error("length not plus one");
    a_start_fields: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        host_req.wr && host_req.addr == OFS_RX_START
        |=> rx_stream == $past(host_req.wdata[13:9])
        && rx_first_channel == $past(host_req.wdata[8:0]))
        else $error("start fields wrong");
    // a bit on another stream never counts, whatever its channel
    a_window_stream: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rx_bit.valid && rx_bit.stream != rx_stream |-> !rx_in_window)
        else $error("window open on wrong stream");
    // the start channel is always inside, even with the shortest length
    a_window_first: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rx_bit.valid && rx_bit.stream == rx_stream && rx_bit.channel == rx_first_channel
        |-> rx_in_window)
        else $error("first channel not in window");
    a_window_before: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rx_bit.valid && {1'b0, rx_bit.channel} + 10'h001 == {1'b0, rx_first_channel}
        |-> !rx_in_window)
        else $error("channel before start in window");
    // widened to ten bits so that a window reaching channel 511 does not wrap
    a_window_last: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rx_bit.valid && rx_bit.stream == rx_stream
        && {1'b0, rx_bit.channel} + 10'h001 == {1'b0, rx_first_channel} + rx_channel_count
        |-> rx_in_window)
        else $error("last channel not in window");
    a_window_past: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rx_bit.valid && {1'b0, rx_bit.channel} == {1'b0, rx_first_channel} + rx_channel_count
        |-> !rx_in_window)
        else $error("channel past the end in window");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the rate outputs and the read port
    a_lfast_rates: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        local_fast_mode |-> local_in_rate[0] == RATE_32M
        && local_out_rate[LOCAL_N-1] == RATE_UNUSED)
        else $error("local fast mode wrong");
    a_bfast_rates: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        backplane_fast_mode |-> bp_out_rate[0] == RATE_32M
        && bp_in_rate[BP_N-1] == RATE_UNUSED)
        else $error("backplane fast mode wrong");
    a_rate_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        host_req.wr && host_req.addr == OFS_BP_IN && !backplane_fast_mode
        ##1 !backplane_fast_mode
        |-> bp_in_rate[0] == brr_rate_t'({1'b0, $past(host_req.wdata[1:0])}))
        else $error("rate field not applied");
    a_rd_window: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !host_req.rd |=> host_rdata == 16'h0000)
        else $error("read data stray");

    // one copy per stream, so that a wrong offset decode on any stream shows up
    for (genvar s = 0; s < LOCAL_N; s++) begin : g_chk_local
        a_lin_write: assert property (
            @(posedge sys_clk) disable iff (!rst_n)
            host_req.wr && host_req.addr == OFS_LOCAL_IN + 9'(s) ##1 !local_fast_mode
            |-> local_in_rate[s] == brr_rate_t'({1'b0, $past(host_req.wdata[1:0])}))
            else $error("local input rate not applied");
        a_lout_write: assert property (
            @(posedge sys_clk) disable iff (!rst_n)
            host_req.wr && host_req.addr == OFS_LOCAL_OUT + 9'(s) ##1 !local_fast_mode
            |-> local_out_rate[s] == brr_rate_t'({1'b0, $past(host_req.wdata[1:0])}))
            else $error("local output rate not applied");
        if (s < LOCAL_N / 2) begin : g_fast
            a_local_fast: assert property (
                @(posedge sys_clk) disable iff (!rst_n)
                local_fast_mode |-> local_in_rate[s] == RATE_32M
                && local_out_rate[s] == RATE_32M)
                else $error("local fast stream not at 32");
        end else begin : g_idle
            a_local_idle: assert property (
                @(posedge sys_clk) disable iff (!rst_n)
                local_fast_mode |-> local_in_rate[s] == RATE_UNUSED
                && local_out_rate[s] == RATE_UNUSED)
                else $error("local upper stream not unused");
        end
    end

    // the same per backplane stream
    for (genvar s = 0; s < BP_N; s++) begin : g_chk_bp
        a_bin_write: assert property (
            @(posedge sys_clk) disable iff (!rst_n)
            host_req.wr && host_req.addr == OFS_BP_IN + 9'(s) ##1 !backplane_fast_mode
            |-> bp_in_rate[s] == brr_rate_t'({1'b0, $past(host_req.wdata[1:0])}))
            else $error("backplane input rate not applied");
        a_bout_write: assert property (
            @(posedge sys_clk) disable iff (!rst_n)
            host_req.wr && host_req.addr == OFS_BP_OUT + 9'(s) ##1 !backplane_fast_mode
            |-> bp_out_rate[s] == brr_rate_t'({1'b0, $past(host_req.wdata[1:0])}))
            else $error("backplane output rate not applied");
        if (s < BP_N / 2) begin : g_fast
            a_bp_fast: assert property (
                @(posedge sys_clk) disable iff (!rst_n)
                backplane_fast_mode |-> bp_in_rate[s] == RATE_32M
                && bp_out_rate[s] == RATE_32M)
                else $error("backplane fast stream not at 32");
        end else begin : g_idle
            a_bp_idle: assert property (
                @(posedge sys_clk) disable iff (!rst_n)
                backplane_fast_mode |-> bp_in_rate[s] == RATE_UNUSED
                && bp_out_rate[s] == RATE_UNUSED)
                else $error("backplane upper stream not unused");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main scenarios to be reached
    c_saturate: cover property (@(posedge sys_clk) disable iff (!rst_n)
        bp_test_error_count == COUNT_MAX);
    c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) bp_counter_clear);
    c_lfast: cover property (@(posedge sys_clk) disable iff (!rst_n) local_fast_mode);
    c_bfast: cover property (@(posedge sys_clk) disable iff (!rst_n) backplane_fast_mode);
    c_window_error: cover property (@(posedge sys_clk) disable iff (!rst_n)
        hit && rx_bit.bit_rx != rx_bit.bit_exp);
endmodule

// ===== brr_pkg.sv
// package for the error-test receiver and stream rate register bank
// assumes a 16-bit host register port with word offsets as printed
package brr_pkg;
    localparam int unsigned ADDR_W = 9;
    localparam logic [8:0] OFS_RX_LENGTH = 9'h0ca;
    localparam logic [8:0] OFS_RX_START = 9'h0cb;
    localparam logic [8:0] OFS_ERR_COUNT = 9'h0cc;
    localparam logic [8:0] OFS_LOCAL_IN = 9'h0cd;
    localparam logic [8:0] OFS_LOCAL_OUT = 9'h0ed;
    localparam logic [8:0] OFS_BP_IN = 9'h10d;
    localparam logic [8:0] OFS_BP_OUT = 9'h12d;
    localparam logic [8:0] OFS_TEST_CTRL = 9'h14e;
    localparam int unsigned LEN_MSB = 8;
    localparam int unsigned STREAM_MSB = 13;
    localparam int unsigned STREAM_LSB = 9;
    localparam int unsigned CHAN_MSB = 8;
    localparam int unsigned CTRL_CLEAR_BIT = 0;
    localparam int unsigned CTRL_LFAST_BIT = 1;
    localparam int unsigned CTRL_BFAST_BIT = 2;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // per-stream rate as seen by the stream logic
    typedef enum logic [2:0] {
        RATE_2M = 3'b000,
        RATE_4M = 3'b001,
        RATE_8M = 3'b010,
        RATE_16M = 3'b011,
        RATE_32M = 3'b100,
        RATE_UNUSED = 3'b111
    } brr_rate_t;

    // register port request
    typedef struct packed {
        logic [8:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } brr_req_t;

    // one received bit from the backplane test receiver front end
    typedef struct packed {
        logic valid;
        logic [4:0] stream;
        logic [8:0] channel;
        logic bit_rx;
        logic bit_exp;
    } brr_rx_bit_t;
endpackage

// ===== tb_ber_rx_and_stream_rate_regs.sv
// testbench for the error-test receiver setup, error counter and stream rate registers
// assumes brr_pkg is compiled first; the bench drives every port itself
`timescale 1ns/10ps
module tb_ber_rx_and_stream_rate_regs;
    import brr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    brr_req_t host_req = '0;
    brr_rx_bit_t rx_bit = '0;
    logic [15:0] host_rdata;
    logic [4:0] rx_stream;
    logic [8:0] rx_first_channel;
    logic [9:0] rx_channel_count;
    logic rx_in_window;
    brr_rate_t local_in_rate [16];
    brr_rate_t local_out_rate [16];
    brr_rate_t bp_in_rate [32];
    brr_rate_t bp_out_rate [32];
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 43612;
    logic [1:0] shadow [4][32];
    logic [15:0] d;
    logic [15:0] exp_count = 16'h0000;
    logic [4:0] ws;
    logic [8:0] wf;
    logic [8:0] wl;
    brr_rate_t er;
    int g;
    int i;
    int k;
    int n;

    brr_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req),
        .host_rdata(host_rdata), .rx_bit(rx_bit), .rx_stream(rx_stream),
        .rx_first_channel(rx_first_channel), .rx_channel_count(rx_channel_count),
        .rx_in_window(rx_in_window), .local_in_rate(local_in_rate),
        .local_out_rate(local_out_rate), .bp_in_rate(bp_in_rate), .bp_out_rate(bp_out_rate));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling leaves room over the saturation run
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reporting and comparison
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rate(string what, brr_rate_t exp, brr_rate_t got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // host port cycles: strobes one cycle long, read data sampled in the next cycle
    task automatic wr(logic [8:0] a, logic [15:0] v);
        @(posedge sys_clk);
        host_req.addr <= a;
        host_req.wdata <= v;
        host_req.wr <= 1'b1;
        @(posedge sys_clk);
        host_req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [8:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        host_req.addr <= a;
        host_req.rd <= 1'b1;
        @(posedge sys_clk);
        host_req.rd <= 1'b0;
        #1;
        v = host_rdata;
    endtask
    // one received bit; the bench keeps its own saturating count model
    task automatic send(logic [4:0] s, logic [8:0] c, logic err, logic chk);
        logic e;
        logic win;
        e = 1'($random(seed));
        win = (s == ws) && (c >= wf) && ({1'b0, c} <= {1'b0, wf} + {1'b0, wl});
        @(posedge sys_clk);
        rx_bit <= '{1'b1, s, c, e ^ err, e};
        #1;
        if (chk) chk16("in_window", 16'(win), 16'(rx_in_window));
        if (win && err && exp_count != 16'hffff) exp_count++;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // expectation helpers and rate output selection
    function automatic brr_rate_t exp_rate(logic fast, int idx, int lim, logic [1:0] f);
        if (fast) return (idx < lim) ? RATE_32M : RATE_UNUSED;
        return brr_rate_t'({1'b0, f});
    endfunction
    function automatic int cnt(int grp);
        return (grp < 2) ? 16 : 32;
    endfunction
    function automatic logic [8:0] base_of(int grp);
        case (grp)
            0: return OFS_LOCAL_IN;
            1: return OFS_LOCAL_OUT;
            2: return OFS_BP_IN;
            default: return OFS_BP_OUT;
        endcase
    endfunction
    function automatic brr_rate_t get_rate(int grp, int idx);
        case (grp)
            0: return local_in_rate[idx];
            1: return local_out_rate[idx];
            2: return bp_in_rate[idx];
            default: return bp_out_rate[idx];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_RX_LENGTH, d);
        chk16("rx_length reset", 16'h0000, d);
        rd(OFS_RX_START, d);
        chk16("rx_start reset", 16'h0000, d);
        rd(OFS_ERR_COUNT, d);
        chk16("count reset", 16'h0000, d);
        chk16("chan_count reset", 16'h0001, {6'h0, rx_channel_count});
        // every code in each group first, then random fields with reserved bits zero
        for (g = 0; g < 4; g++) begin
            for (i = 0; i < cnt(g); i++) begin
                chk_rate("rate reset", RATE_2M, get_rate(g, i));
                shadow[g][i] = (i < 4) ? 2'(i) : 2'($random(seed));
                wr(base_of(g) + 9'(i), {14'h0, shadow[g][i]});
            end
        end
        // all four fast-mode combinations, local and backplane independent
        for (k = 0; k < 4; k++) begin
            wr(OFS_TEST_CTRL, {13'h0, k[1], k[0], 1'b0});
            for (g = 0; g < 4; g++) begin
                for (i = 0; i < cnt(g); i++) begin
                    er = exp_rate((g < 2) ? k[0] : k[1], i, cnt(g) / 2, shadow[g][i]);
                    case (g)
                        0: chk_rate("rate", er, get_rate(g, i));
                        1: chk_rate("rate", er, get_rate(g, i));
                        2: chk_rate("rate", er, get_rate(g, i));
                        default: chk_rate("rate", er, get_rate(g, i));
                    endcase
                    if (k == 0) rd(base_of(g) + 9'(i), d);
                    if (k == 0) chk16("rate readback", {14'h0, shadow[g][i]}, d);
                end
            end
        end
        wr(OFS_TEST_CTRL, 16'h0000);
        // largest length, reserved bits dropped
        wr(OFS_RX_LENGTH, 16'hffff);
        rd(OFS_RX_LENGTH, d);
        chk16("rx_length max", 16'h01ff, d);
        chk16("chan_count max", 16'h0200, {6'h0, rx_channel_count});
        ws = 5'($random(seed));
        wf = 9'($unsigned($random(seed)) % 400 + 1);
        wl = 9'($unsigned($random(seed)) % 20);
        wr(OFS_RX_START, {2'b00, ws, wf});
        wr(OFS_RX_LENGTH, {7'h0, wl});
        rd(OFS_RX_START, d);
        chk16("rx_start", {2'b00, ws, wf}, d);
        chk16("rx_stream", {11'h0, ws}, {11'h0, rx_stream});
        chk16("first_chan", {7'h0, wf}, {7'h0, rx_first_channel});
        chk16("chan_count", {7'h0, wl} + 16'h1, {6'h0, rx_channel_count});
        // sweep one channel either side of the window, on and off the stream
        for (n = 0; n < 240; n++) begin
            send(n[2] ? ws : ws + 5'h1, wf + 9'(n % (wl + 3)) - 9'h1, 1'($random(seed)), 1'b1);
        end
        @(posedge sys_clk);
        rx_bit.valid <= 1'b0;
        rd(OFS_ERR_COUNT, d);
        chk16("count", exp_count, d);
        wr(OFS_ERR_COUNT, 16'h1234);
        rd(OFS_ERR_COUNT, d);
        chk16("count after write", exp_count, d);
        wr(OFS_TEST_CTRL, 16'h0001);
        exp_count = 16'h0000;
        rd(OFS_ERR_COUNT, d);
        chk16("count cleared", exp_count, d);
        // run past the top of the counter, then check it holds until cleared
        for (n = 0; n < 65545; n++) begin
            send(ws, wf + wl, 1'b1, 1'b0);
        end
        @(posedge sys_clk);
        rx_bit.valid <= 1'b0;
        rd(OFS_ERR_COUNT, d);
        chk16("count saturated", exp_count, d);
        rd(OFS_TEST_CTRL, d);
        chk16("ctrl readback", 16'h0000, d);
        wr(OFS_TEST_CTRL, 16'h0001);
        exp_count = 16'h0000;
        rd(OFS_ERR_COUNT, d);
        chk16("count cleared again", exp_count, d);
        rd(9'h1ff, d);
        chk16("unmapped", 16'h0000, d);
        // gaps behind the local blocks; these would alias stream 3, which holds 11
        rd(OFS_LOCAL_IN + 9'h013, d);
        chk16("local in gap", 16'h0000, d);
        rd(OFS_LOCAL_OUT + 9'h013, d);
        chk16("local out gap", 16'h0000, d);
        results();
    end
endmodule
